// ---- nv_self_prog_seq.sv ----
// top: run-time self-programming sequencer with APB register access
`timescale 1ns/1ps
`default_nettype none
module nv_self_prog_seq #(
	parameter int ERASE_CNT = nv_seq_pkg::ERASE_CYCLES,
	parameter int WORD_CNT = nv_seq_pkg::WORD_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [nv_seq_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cpu_stall,
	output logic array_go,
	output logic array_erase,
	output logic [nv_seq_pkg::TARGET_W-1:0] array_addr
);
	import nv_seq_pkg::*;

	// internal carrier to the array timer; the pins below are registered copies
	nv_array_if link ();

	// -----------------------------------------
	// bus decode
	// -----------------------------------------
	logic wr_en;
	logic rd_en;
	logic hit;
	logic sel_ctl;
	logic sel_key;
	logic sel_high;
	logic sel_low;
	// a transfer counts only at the edge where the access phase is answered
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && penable && pready && !pwrite;

	// one select per register; any other address is unmapped
	always_comb begin
		sel_ctl = 1'b0;
		sel_key = 1'b0;
		sel_high = 1'b0;
		sel_low = 1'b0;
		if (paddr == OFS_CONTROL) begin
			sel_ctl = 1'b1;
		end else if (paddr == OFS_KEY) begin
			sel_key = 1'b1;
		end else if (paddr == OFS_ADDR_HIGH) begin
			sel_high = 1'b1;
		end else if (paddr == OFS_ADDR_LOW) begin
			sel_low = 1'b1;
		end
	end
	assign hit = sel_ctl || sel_key || sel_high || sel_low;

	// -----------------------------------------
	// registers
	// -----------------------------------------
	logic [CTL_OP_W-1:0] op_sel_r;
	logic start_r;
	logic err_r;
	logic [7:0] addr_high_r;
	logic [15:0] addr_low_r;
	logic key_half_r;
	logic unlocked_r;
	seq_state_e state_r;
	seq_state_e state_nxt;
	logic start_wr;
	logic start_ok;
	logic op_valid;

	// only the two defined operation codes may launch
	assign op_valid = (pwdata[CTL_OP_LSB +: CTL_OP_W] == OP_PROGRAM_PAIR) ||
		(pwdata[CTL_OP_LSB +: CTL_OP_W] == OP_ERASE_PAGE);

	// start write is only honoured while idle and unlocked
	assign start_wr = wr_en && sel_ctl && pwdata[CTL_START_BIT];
	assign start_ok = start_wr && unlocked_r && (state_r == ST_IDLE) && op_valid;

	// upper address byte; frozen while an operation runs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addr_high_r <= ADDR_HIGH_RESET;
		end else if (wr_en && sel_high && state_r == ST_IDLE) begin
			addr_high_r <= pwdata[7:0];
		end
	end

	// lower address half-word; frozen while an operation runs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addr_low_r <= ADDR_LOW_RESET;
		end else if (wr_en && sel_low && state_r == ST_IDLE) begin
			addr_low_r <= pwdata[15:0];
		end
	end

	// operation select, also frozen while busy
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			op_sel_r <= CONTROL_RESET[CTL_OP_LSB +: CTL_OP_W];
		end else if (wr_en && paddr == OFS_CONTROL && state_r == ST_IDLE) begin
			op_sel_r <= pwdata[CTL_OP_LSB +: CTL_OP_W];
		end
	end

	// first key half: set by 0x55, dropped by any other write, so
	// no other write may come between the two halves
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			key_half_r <= 1'b0;
		end else if (wr_en) begin
			key_half_r <= sel_key && (pwdata[7:0] == KEY_FIRST);
		end
	end

	// unlock: set only by 0xaa right after 0x55; any other write, the control
	// write that it enables included, spends it, so start must follow at once
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			unlocked_r <= 1'b0;
		end else if (wr_en) begin
			unlocked_r <= sel_key && key_half_r && (pwdata[7:0] == KEY_SECOND);
		end
	end

	// refused start flag: sticky, cleared by writing control with bit 13 set;
	// a new refusal in the same cycle wins over the clear
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			err_r <= 1'b0;
		end else if (start_wr && !start_ok) begin
			err_r <= 1'b1;
		end else if (wr_en && paddr == OFS_CONTROL && pwdata[CTL_ERR_BIT]) begin
			err_r <= 1'b0;
		end
	end

	// -----------------------------------------
	// sequencer state machine
	// -----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_ok) begin
					state_nxt = ST_LAUNCH;
				end
			end
			ST_LAUNCH: begin
				state_nxt = ST_BUSY;
			end
			ST_BUSY: begin
				if (link.done) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// start bit set by an accepted start, cleared by hardware at completion
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			start_r <= CONTROL_RESET[CTL_START_BIT];
		end else if (start_ok) begin
			start_r <= 1'b1;
		end else if (state_r == ST_DONE) begin
			start_r <= 1'b0;
		end
	end

	// -----------------------------------------
	// array request
	// -----------------------------------------
	logic [TARGET_W-1:0] target;
	logic [TARGET_W-1:0] target_aligned;
	assign target = {addr_high_r, addr_low_r};
	// erase masks down to the page base; program lands on the pair boundary
	assign target_aligned = (op_sel_r == OP_ERASE_PAGE) ?
		(target & ~TARGET_W'((1 << PAGE_WORDS_LOG2) - 1)) :
		{target[TARGET_W-1:2], PAIR_BASE_LOW};

	// go is a single-cycle pulse; address and kind stay frozen until idle
	assign link.go = (state_r == ST_LAUNCH);
	assign link.erase = (op_sel_r == OP_ERASE_PAGE);
	assign link.addr = target_aligned;

	nv_array_timer #(
		.ERASE_CNT(ERASE_CNT),
		.WORD_CNT(WORD_CNT)
	) u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.arr(link)
	);

	// -----------------------------------------
	// array pins and processor stall
	// -----------------------------------------

	// registered array pins; they trail the internal request by one cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			array_go <= 1'b0;
			array_erase <= 1'b0;
			array_addr <= '0;
		end else begin
			array_go <= link.go;
			array_erase <= link.erase;
			array_addr <= link.addr;
		end
	end

	// stall rises at the accepting edge and falls with the return to idle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cpu_stall <= 1'b0;
		end else begin
			cpu_stall <= start_ok || (state_nxt != ST_IDLE);
		end
	end

	// -----------------------------------------
	// apb answer: no wait states, unmapped gives pslverr
	// -----------------------------------------
	logic [31:0] rd_mux;

	// read mux; the key register is write-only and reads as zero
	always_comb begin
		rd_mux = 32'h0;
		if (sel_ctl) begin
			rd_mux = {16'h0, start_r, 1'b0, err_r, 11'h0, op_sel_r};
		end else if (sel_high) begin
			rd_mux = {24'h0, addr_high_r};
		end else if (sel_low) begin
			rd_mux = {16'h0, addr_low_r};
		end
	end

	// ready and error answer the setup cycle, so no access has a wait state
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit;
		end
	end

	// read data captured in the setup cycle, valid in the single access cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end else begin
			prdata <= 32'h0;
		end
	end

	// writes and reads in the access phase act only once pready is high
	logic unused_rd;
	assign unused_rd = rd_en;
endmodule : nv_self_prog_seq
`default_nettype wire

// ---- nv_seq_pkg.sv ----
// package: register map, field positions and timing for the self-programming sequencer
package nv_seq_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_KEY = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_ADDR_HIGH = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_ADDR_LOW = 12'h00c;
	localparam int CTL_START_BIT = 15;
	localparam int CTL_ERR_BIT = 13;
	localparam int CTL_OP_LSB = 0;
	localparam int CTL_OP_W = 2;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;
	localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam int TARGET_W = 24;
	localparam int CLK_HZ = 25000000;
	localparam int ERASE_TIME_US = 20000;
	localparam int WORD_TIME_US = 50;
	localparam int ERASE_CYCLES = (ERASE_TIME_US * (CLK_HZ / 1000000));
	localparam int WORD_CYCLES = (WORD_TIME_US * (CLK_HZ / 1000000));
	localparam int PAGE_WORDS_LOG2 = 10;
	localparam logic [1:0] PAIR_BASE_LOW = 2'h2;
	localparam logic [CTL_OP_W-1:0] OP_PROGRAM_PAIR = 2'h1;
	localparam logic [CTL_OP_W-1:0] OP_ERASE_PAGE = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LAUNCH = 2'b01,
		ST_BUSY = 2'b11,
		ST_DONE = 2'b10
	} seq_state_e;
endpackage : nv_seq_pkg

// ---- nv_array_if.sv ----
// interface: request/complete carrier between sequencer and array timer
`timescale 1ns/1ps
`default_nettype none
interface nv_array_if;
	logic go;
	logic erase;
	logic [23:0] addr;
	logic busy;
	logic done;
	modport seq (output go, output erase, output addr, input busy, input done);
	modport arr (input go, input erase, input addr, output busy, output done);
endinterface : nv_array_if
`default_nettype wire

// ---- nv_array_timer.sv ----
// array-side timer: holds the operation for the full erase or write time
`timescale 1ns/1ps
`default_nettype none
module nv_array_timer #(
	parameter int ERASE_CNT = nv_seq_pkg::ERASE_CYCLES,
	parameter int WORD_CNT = nv_seq_pkg::WORD_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	nv_array_if.arr arr
);
	import nv_seq_pkg::*;

	// -----------------------------------------
	// operation timer
	// -----------------------------------------
	logic [31:0] count_r;
	logic busy_r;
	logic done_r;

	// a go pulse while busy is ignored; the sequencer never issues one
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_r <= 32'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (!busy_r && arr.go) begin
				busy_r <= 1'b1;
				count_r <= arr.erase ? 32'(ERASE_CNT - 1) : 32'(WORD_CNT - 1);
			end else if (busy_r) begin
				if (count_r == 32'h0) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end else begin
					count_r <= count_r - 32'h1;
				end
			end
		end
	end

	assign arr.busy = busy_r;
	assign arr.done = done_r;
endmodule : nv_array_timer
`default_nettype wire

// ---- nv_seq_checker.sv ----
// checker: launch, stall and key-order properties at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module nv_seq_checker #(
	parameter int ERASE_CNT = 20,
	parameter int WORD_CNT = 5
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [nv_seq_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_stall,
	input wire logic array_go,
	input wire logic array_erase,
	input wire logic [nv_seq_pkg::TARGET_W-1:0] array_addr
);
	import nv_seq_pkg::*;
	localparam int STALL_MAX = ERASE_CNT + 8;
	logic first_r;
	logic key_ok_r;
	logic wr;
	logic start;
	logic op_ok;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// only committed writes move the key tracker
	assign wr = psel && penable && pready && pwrite;
	assign start = wr && paddr == OFS_CONTROL && pwdata[CTL_START_BIT] && !cpu_stall;
	assign op_ok = pwdata[1:0] == OP_PROGRAM_PAIR || pwdata[1:0] == OP_ERASE_PAGE;
	// any write between the two key values spoils the unlock
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			first_r <= 1'b0;
			key_ok_r <= 1'b0;
		end else if (wr) begin
			first_r <= paddr == OFS_KEY && pwdata[7:0] == KEY_FIRST;
			key_ok_r <= first_r && paddr == OFS_KEY && pwdata[7:0] == KEY_SECOND;
		end
	end
	sequence s_launch;
		$rose(cpu_stall) ##1 array_go;
	endsequence
	a_ready_access: assert property (psel && !penable |=> pready) else $error("no ready");
	a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
	a_start_launch: assert property (start && key_ok_r && op_ok |=> s_launch) else $error("no launch");
	a_start_refused: assert property (start && !key_ok_r |=> !cpu_stall[*3]) else $error("launch w/o key");
	a_go_single: assert property (array_go |=> !array_go[*4]) else $error("repeat go");
	a_stall_cover: assert property (array_go |-> cpu_stall[*5]) else $error("stall gap");
	a_stall_bound: assert property ($rose(cpu_stall) |-> ##[3:STALL_MAX] !cpu_stall) else $error("stuck");
	a_erase_page: assert property (array_go && array_erase |-> array_addr[9:0] == 10'h000) else $error("page");
	a_pair_align: assert property (array_go && !array_erase |-> array_addr[1:0] == PAIR_BASE_LOW) else $error("pair");
endmodule : nv_seq_checker
`default_nettype wire

// ---- nv_flash_model.sv ----
// model: program flash array as seen through the launch outputs
`timescale 1ns/1ps
`default_nettype none
module nv_flash_model (
	input wire logic clock,
	input wire logic array_go,
	input wire logic array_erase,
	input wire logic [23:0] array_addr,
	output logic [23:0] last_addr,
	output logic last_erase,
	output int op_cnt,
	output logic blank_miss
);
	logic [23:0] erased_r = 24'hffffff;
	initial op_cnt = 0;
	initial blank_miss = 1'b0;
	// a program outside the last erased page would hit unerased cells
	always @(posedge clock) begin
		if (array_go) begin
			op_cnt <= op_cnt + 1;
			last_addr <= array_addr;
			last_erase <= array_erase;
			if (array_erase)
				erased_r <= array_addr >> 10;
			else if ((array_addr >> 10) != erased_r)
				blank_miss <= 1'b1;
		end
	end
endmodule : nv_flash_model
`default_nettype wire

// ---- tb_top.sv ----
// testbench: register-level scenarios for the self-programming sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t: bad value", $time); end end
module tb_top;
	import nv_seq_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, cpu_stall, array_go, array_erase, last_erase, blank_miss, err;
	logic [23:0] array_addr, last_addr;
	int op_cnt;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	always #20 clock = ~clock;
	nv_self_prog_seq #(.ERASE_CNT(20), .WORD_CNT(5)) u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_stall(cpu_stall), .array_go(array_go), .array_erase(array_erase),
		.array_addr(array_addr));
	nv_flash_model u_flash (.clock(clock), .array_go(array_go), .array_erase(array_erase),
		.array_addr(array_addr), .last_addr(last_addr), .last_erase(last_erase), .op_cnt(op_cnt),
		.blank_miss(blank_miss));
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	// address setup, optional key writes, start, wait out the stall, read control
	// keys: 0 none, 1 only 0xaa, 2 full key, 3 key broken by a stray key write
	task automatic run_op(input logic [15:0] lo, input logic [31:0] ctl, input int keys);
		apb(1'b1, OFS_ADDR_HIGH, 32'h12);
		apb(1'b1, OFS_ADDR_LOW, {16'h0, lo});
		if (keys >= 2)
			apb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
		if (keys == 3)
			apb(1'b1, OFS_KEY, 32'h0);
		if (keys > 0)
			apb(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
		apb(1'b1, OFS_CONTROL, ctl);
		// no bus traffic while stalled; the wait ends when cpu_stall falls low
		while (cpu_stall === 1'b1) begin
			@(posedge clock);
		end
		apb(1'b0, OFS_CONTROL, 32'h0);
	endtask : run_op
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		apb(1'b0, OFS_CONTROL, 32'h0); `CHK(rd[15:0], CONTROL_RESET)
		apb(1'b0, OFS_KEY, 32'h0); `CHK(rd, 32'h0)
		apb(1'b0, 12'h010, 32'h0); `CHK(err, 1'b1)
		$display("reset test done");
		run_op(16'h37ff, 32'h8002, 2);
		`CHK({rd[15], last_erase, last_addr}, {2'b01, 24'h123400})
		run_op(16'h3457, 32'h8001, 2);
		`CHK({rd[15], last_erase, last_addr, blank_miss}, {2'b00, 24'h123456, 1'b0})
		$display("operation test done");
		apb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
		run_op(16'h0, 32'h8001, 1);
		`CHK({rd[15], rd[13]}, 2'b01)
		apb(1'b1, OFS_CONTROL, 32'h2000);
		apb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
		apb(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
		run_op(16'h0, 32'h8002, 0);
		`CHK({rd[15], rd[13], op_cnt}, {2'b01, 32'd2})
		apb(1'b1, OFS_CONTROL, 32'h2000);
		run_op(16'h0, 32'h8001, 3);
		`CHK({rd[15], rd[13], op_cnt}, {2'b01, 32'd2})
		apb(1'b1, OFS_CONTROL, 32'h2000);
		run_op(16'h0, 32'h8003, 2);
		`CHK({rd[15], rd[13], rd[1:0], op_cnt}, {2'b01, 2'h3, 32'd2})
		$display("refusal test done");
		finish_test();
	end
	// hang guard: far beyond the fewer than two hundred cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			finish_test();
		end
	end
endmodule : tb_top
bind nv_self_prog_seq nv_seq_checker #(.ERASE_CNT(ERASE_CNT), .WORD_CNT(WORD_CNT)) u_chk (.clock(clock),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall), .array_go(array_go),
	.array_erase(array_erase), .array_addr(array_addr));
`default_nettype wire
